// [hdl/mscl_pkg.sv]
package mscl_pkg;

  // ---------------------------------------------------------------
  // Bus and register map
  // ---------------------------------------------------------------
  localparam int         ADDR_W         = 8;
  localparam int         DATA_W         = 32;
  localparam logic [7:0] OFS_DUAL_LINK  = 8'h00;
  localparam logic [7:0] OFS_AUDIO_CFG  = 8'h04;
  localparam logic [7:0] OFS_MAIN_CTL   = 8'h08;
  localparam logic [7:0] OFS_RESELECT   = 8'h0C;
  localparam logic [7:0] OFS_STRAP_STAT = 8'h10;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  localparam int         WR_LANE        = 0;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TXMODE_LSB    = 0;
  localparam int TXMODE_W      = 3;
  localparam int COAX_BIT      = 7;
  localparam int SPLIT_AUD_BIT = 4;
  localparam int CLKSRC_LSB    = 0;
  localparam int CLKSRC_W      = 2;
  localparam int LANES_LSB     = 2;
  localparam int LANES_W       = 2;
  localparam int CONTCLK_BIT   = 7;
  localparam int INDIS_BIT     = 0;
  localparam int STAT_A_LSB    = 0;
  localparam int STAT_B_LSB    = 4;
  localparam int STAT_DONE_BIT = 8;

  // ---------------------------------------------------------------
  // Strap decoding
  // ---------------------------------------------------------------
  localparam int STRAP_W         = 3;
  localparam int STRAP_SPLIT_BIT = 2;
  localparam int STRAP_LANES_LSB = 0;
  localparam int STRAP_CLK_BIT   = 2;
  localparam int STRAP_COAX_BIT  = 1;
  localparam int STRAP_INDIS_BIT = 0;

  // ---------------------------------------------------------------
  // Field encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] TX_MODE_NORMAL = 3'h0;
  localparam logic [2:0] TX_MODE_SPLIT  = 3'h2;
  localparam logic [1:0] CLKSRC_VIDEO   = 2'h0;
  localparam logic [1:0] CLKSRC_EXT     = 2'h1;
  localparam logic [1:0] CLKSRC_INT     = 2'h2;
  localparam logic [1:0] CLKSRC_EXT_DUO = 2'h3;
  localparam logic [1:0] LANES_RST      = 2'h0;
  localparam logic [3:0] LANE_BASE      = 4'hE;
  localparam logic       FLAG_CLR       = 1'b0;
  localparam logic       INDIS_RST      = 1'b1;

  typedef enum logic {
    MSCL_LD_WAIT = 1'b0,
    MSCL_LD_DONE = 1'b1
  } mscl_load_e;

endpackage

// [hdl/mscl_field.sv]
`timescale 1ns/1ns
module mscl_field #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and control
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Strap load
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // Software write
  input  wire logic         wr,
  input  wire logic [W-1:0] wr_val,
  // Field value
  output logic      [W-1:0] value
);

  // Software write takes precedence over the strap value.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      value <= RST_VAL;
    end else if (ce) begin
      if (wr) begin
        value <= wr_val;
      end else if (load) begin
        value <= load_val;
      end
    end
  end

endmodule

// [hdl/mscl_loader.sv]
`timescale 1ns/1ns
// Summary of operation
// - After reset, sample both strap inputs once and load decoded fields.
// - Software may write every strapped field; the write replaces the strap value.
// - Lane count field 00..11 enables one to four video input lanes.
// - Splitter set divides video odd/even across the two serial outputs.
// - Input-disable set keeps video input ports disabled; clear enables them.
// - Cable-type set selects coaxial serial outputs; clear selects twisted pair.
// - Clock mode 0 uses external oscillator; input clock may be discontinuous.
// - Clock mode 1 uses video input clock, which must then run continuously.
// - Splitter strap sets transmit mode field and split-audio bit.
// - Clock strap sets continuous-clock bit and clock source field.
module mscl_loader (
  // Clock, reset and enable
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Strap inputs
  input  wire logic [2:0]  config_strap_a,
  input  wire logic [2:0]  config_strap_b,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Configuration outputs
  output logic [3:0]       lane_enable,
  output logic             split_video_en,
  output logic             split_audio_en,
  output logic             input_port_enable,
  output logic             coax_cable_flag,
  output logic             ref_from_video_clk,
  output logic             ref_from_ext_osc,
  output logic             discontinuous_clk_ok,
  output logic             config_loaded
);

  // ---------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------
  mscl_pkg::mscl_load_e load_state;
  mscl_pkg::mscl_load_e next_load_state;
  wire logic            strap_load;
  wire logic            strap_split;
  wire logic [1:0]      strap_lanes;
  wire logic            strap_clk_video;
  wire logic [2:0]      strap_tx_mode;
  wire logic [1:0]      strap_clksrc;

  assign strap_load      = ce && (load_state == mscl_pkg::MSCL_LD_WAIT);
  assign strap_split     = config_strap_a[mscl_pkg::STRAP_SPLIT_BIT];
  assign strap_lanes     = config_strap_a[mscl_pkg::STRAP_LANES_LSB +: mscl_pkg::LANES_W];
  assign strap_clk_video = !config_strap_b[mscl_pkg::STRAP_CLK_BIT];
  assign strap_tx_mode   = strap_split ? mscl_pkg::TX_MODE_SPLIT : mscl_pkg::TX_MODE_NORMAL;
  assign strap_clksrc    = strap_clk_video ? mscl_pkg::CLKSRC_VIDEO : mscl_pkg::CLKSRC_EXT;

  always_comb begin
    unique case (load_state)
      mscl_pkg::MSCL_LD_WAIT: next_load_state = mscl_pkg::MSCL_LD_DONE;
      mscl_pkg::MSCL_LD_DONE: next_load_state = mscl_pkg::MSCL_LD_DONE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      load_state <= mscl_pkg::MSCL_LD_WAIT;
    end else if (ce) begin
      load_state <= next_load_state;
    end
  end

  logic [2:0] strap_a_seen;
  logic [2:0] strap_b_seen;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      strap_a_seen <= '0;
      strap_b_seen <= '0;
    end else if (strap_load) begin
      strap_a_seen <= config_strap_a;
      strap_b_seen <= config_strap_b;
    end
  end

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  wire logic   wr_fire;
  wire logic   wr_lane0;
  wire logic   wr_dual;
  wire logic   wr_audio;
  wire logic   wr_main;
  wire logic   wr_resel;
  wire logic   wr_mapped;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = ce && aw_held && w_held && !s_axi_bvalid;
  assign wr_lane0      = wr_fire && w_strb_q[mscl_pkg::WR_LANE];
  assign wr_dual       = wr_lane0 && (aw_addr_q == mscl_pkg::OFS_DUAL_LINK);
  assign wr_audio      = wr_lane0 && (aw_addr_q == mscl_pkg::OFS_AUDIO_CFG);
  assign wr_main       = wr_lane0 && (aw_addr_q == mscl_pkg::OFS_MAIN_CTL);
  assign wr_resel      = wr_lane0 && (aw_addr_q == mscl_pkg::OFS_RESELECT);
  assign wr_mapped     = (aw_addr_q == mscl_pkg::OFS_DUAL_LINK) || (aw_addr_q == mscl_pkg::OFS_AUDIO_CFG)
                      || (aw_addr_q == mscl_pkg::OFS_MAIN_CTL) || (aw_addr_q == mscl_pkg::OFS_RESELECT);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_held   <= 1'b0;
      aw_addr_q <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      w_held   <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held   <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= mscl_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? mscl_pkg::RESP_OKAY : mscl_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration fields
  // ---------------------------------------------------------------
  logic [2:0] tx_mode;
  logic       coax;
  logic       split_audio;
  logic [1:0] clksrc;
  logic [1:0] lanes;
  logic       cont_clk;
  logic       in_dis;

  mscl_field #(.W(mscl_pkg::TXMODE_W), .RST_VAL(mscl_pkg::TX_MODE_NORMAL)) u_tx_mode (
    .core_clk (core_clk), .rst (rst), .ce (ce), .load (strap_load), .load_val (strap_tx_mode),
    .wr (wr_dual), .wr_val (w_data_q[mscl_pkg::TXMODE_LSB +: mscl_pkg::TXMODE_W]), .value (tx_mode));
  mscl_field #(.W(1), .RST_VAL(mscl_pkg::FLAG_CLR)) u_coax (
    .core_clk (core_clk), .rst (rst), .ce (ce), .load (strap_load),
    .load_val (config_strap_b[mscl_pkg::STRAP_COAX_BIT]),
    .wr (wr_dual), .wr_val (w_data_q[mscl_pkg::COAX_BIT]), .value (coax));
  mscl_field #(.W(1), .RST_VAL(mscl_pkg::FLAG_CLR)) u_split_audio (
    .core_clk (core_clk), .rst (rst), .ce (ce), .load (strap_load), .load_val (strap_split),
    .wr (wr_audio), .wr_val (w_data_q[mscl_pkg::SPLIT_AUD_BIT]), .value (split_audio));
  mscl_field #(.W(mscl_pkg::CLKSRC_W), .RST_VAL(mscl_pkg::CLKSRC_EXT)) u_clksrc (
    .core_clk (core_clk), .rst (rst), .ce (ce), .load (strap_load), .load_val (strap_clksrc),
    .wr (wr_main), .wr_val (w_data_q[mscl_pkg::CLKSRC_LSB +: mscl_pkg::CLKSRC_W]), .value (clksrc));
  mscl_field #(.W(mscl_pkg::LANES_W), .RST_VAL(mscl_pkg::LANES_RST)) u_lanes (
    .core_clk (core_clk), .rst (rst), .ce (ce), .load (strap_load), .load_val (strap_lanes),
    .wr (wr_main), .wr_val (w_data_q[mscl_pkg::LANES_LSB +: mscl_pkg::LANES_W]), .value (lanes));
  mscl_field #(.W(1), .RST_VAL(mscl_pkg::FLAG_CLR)) u_cont_clk (
    .core_clk (core_clk), .rst (rst), .ce (ce), .load (strap_load), .load_val (strap_clk_video),
    .wr (wr_main), .wr_val (w_data_q[mscl_pkg::CONTCLK_BIT]), .value (cont_clk));
  mscl_field #(.W(1), .RST_VAL(mscl_pkg::INDIS_RST)) u_in_dis (
    .core_clk (core_clk), .rst (rst), .ce (ce), .load (strap_load),
    .load_val (config_strap_b[mscl_pkg::STRAP_INDIS_BIT]),
    .wr (wr_resel), .wr_val (w_data_q[mscl_pkg::INDIS_BIT]), .value (in_dis));

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  wire logic [31:0] dual_word;
  wire logic [31:0] audio_word;
  wire logic [31:0] main_word;
  wire logic [31:0] resel_word;
  wire logic [31:0] stat_word;
  wire logic [31:0] rd_word;
  wire logic        rd_mapped;

  assign dual_word  = (32'(tx_mode) << mscl_pkg::TXMODE_LSB) | (32'(coax) << mscl_pkg::COAX_BIT);
  assign audio_word = 32'(split_audio) << mscl_pkg::SPLIT_AUD_BIT;
  assign main_word  = (32'(clksrc) << mscl_pkg::CLKSRC_LSB) | (32'(lanes) << mscl_pkg::LANES_LSB)
                    | (32'(cont_clk) << mscl_pkg::CONTCLK_BIT);
  assign resel_word = 32'(in_dis) << mscl_pkg::INDIS_BIT;
  assign stat_word  = (32'(strap_a_seen) << mscl_pkg::STAT_A_LSB) | (32'(strap_b_seen) << mscl_pkg::STAT_B_LSB)
                    | (32'(config_loaded) << mscl_pkg::STAT_DONE_BIT);
  assign rd_word    = (s_axi_araddr == mscl_pkg::OFS_DUAL_LINK)  ? dual_word  :
                      (s_axi_araddr == mscl_pkg::OFS_AUDIO_CFG)  ? audio_word :
                      (s_axi_araddr == mscl_pkg::OFS_MAIN_CTL)   ? main_word  :
                      (s_axi_araddr == mscl_pkg::OFS_RESELECT)   ? resel_word :
                      (s_axi_araddr == mscl_pkg::OFS_STRAP_STAT) ? stat_word  : '0;
  assign rd_mapped  = (s_axi_araddr == mscl_pkg::OFS_DUAL_LINK) || (s_axi_araddr == mscl_pkg::OFS_AUDIO_CFG)
                   || (s_axi_araddr == mscl_pkg::OFS_MAIN_CTL) || (s_axi_araddr == mscl_pkg::OFS_RESELECT)
                   || (s_axi_araddr == mscl_pkg::OFS_STRAP_STAT);
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= mscl_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_mapped ? mscl_pkg::RESP_OKAY : mscl_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration outputs
  // ---------------------------------------------------------------
  wire logic [3:0] lane_mask;

  assign lane_mask = ~(mscl_pkg::LANE_BASE << lanes);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lane_enable          <= '0;
      split_video_en       <= 1'b0;
      split_audio_en       <= 1'b0;
      input_port_enable    <= 1'b0;
      coax_cable_flag      <= 1'b0;
      ref_from_video_clk   <= 1'b0;
      ref_from_ext_osc     <= 1'b0;
      discontinuous_clk_ok <= 1'b0;
      config_loaded        <= 1'b0;
    end else if (ce) begin
      lane_enable          <= lane_mask;
      split_video_en       <= (tx_mode == mscl_pkg::TX_MODE_SPLIT);
      split_audio_en       <= split_audio;
      input_port_enable    <= !in_dis;
      coax_cable_flag      <= coax;
      ref_from_video_clk   <= (clksrc == mscl_pkg::CLKSRC_VIDEO);
      ref_from_ext_osc     <= (clksrc == mscl_pkg::CLKSRC_EXT) || (clksrc == mscl_pkg::CLKSRC_EXT_DUO);
      discontinuous_clk_ok <= !cont_clk;
      config_loaded        <= (load_state == mscl_pkg::MSCL_LD_DONE) || strap_load;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_strap_load;
    strap_load && !wr_fire;
  endsequence

  sequence s_main_write;
    wr_main;
  endsequence

  AST_LOAD_ONCE: assert property (config_loaded |=> config_loaded && !strap_load)
    else $error("strap sampling repeated after first load");
  AST_LOAD_LANES: assert property (s_strap_load |=> lanes == $past(config_strap_a[1:0]))
    else $error("lane field does not match strap a");
  AST_SW_OVERRIDE: assert property (s_main_write |=> lanes == $past(w_data_q[3:2]))
    else $error("software write did not replace lane field");
  AST_LANE_DECODE: assert property (ce && lanes == 2'h1 |=> lane_enable == 4'h3)
    else $error("two-lane setting did not enable two lanes");
  AST_SPLIT_OUT: assert property (ce && tx_mode == mscl_pkg::TX_MODE_SPLIT |=> split_video_en)
    else $error("split mode did not enable video split");
  AST_INPUT_DIS: assert property (ce && in_dis |=> !input_port_enable)
    else $error("inputs enabled while disable set");
  AST_COAX_OUT: assert property (ce && $changed(coax) |=> coax_cable_flag == $past(coax))
    else $error("cable type output does not follow field");
  AST_CLK_EXT: assert property (s_strap_load ##0 config_strap_b[2] |=> clksrc == mscl_pkg::CLKSRC_EXT && !cont_clk ##1 (!ce || ref_from_ext_osc))
    else $error("clock mode 0 did not select external oscillator");
  AST_CLK_VIDEO: assert property (s_strap_load ##0 !config_strap_b[2] |=> cont_clk && clksrc == mscl_pkg::CLKSRC_VIDEO)
    else $error("clock mode 1 did not select video clock");
  AST_SPLIT_LOAD: assert property (s_strap_load |=> split_audio == $past(config_strap_a[2]) && (tx_mode == mscl_pkg::TX_MODE_SPLIT) == split_audio)
    else $error("splitter strap not loaded into both fields");
  AST_STRAP_B: assert property (s_strap_load |=> coax == $past(config_strap_b[1]) && in_dis == $past(config_strap_b[0]))
    else $error("strap b decode wrong");
  AST_WR_RESP: assert property (wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response missing");

endmodule

// [verif/mscl_strap_model.sv]
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Strap divider model
// ---------------------------------------------------------------
module mscl_strap_model (
  // Fitted resistor pair, given as a mode number
  input  wire logic [2:0] mode_a,
  input  wire logic [2:0] mode_b,
  // Decoded strap levels
  output logic      [2:0] config_strap_a,
  output logic      [2:0] config_strap_b
);
  // A fitted divider holds a steady level and changes only when the board is restrapped.
  assign config_strap_a = mode_a;
  assign config_strap_b = mode_b;
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ns
module testbench;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic        ce       = 1'b1;
  logic [2:0]  mode_a   = 3'h0;
  logic [2:0]  mode_b   = 3'h0;
  logic [2:0]  config_strap_a;
  logic [2:0]  config_strap_b;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_wready;
  logic [31:0] s_axi_wdata   = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb   = 4'h0;
  logic        s_axi_bvalid;
  logic        s_axi_bready  = 1'b0;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic        s_axi_rvalid;
  logic        s_axi_rready  = 1'b0;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic [3:0]  lane_enable;
  logic        split_video_en;
  logic        split_audio_en;
  logic        input_port_enable;
  logic        coax_cable_flag;
  logic        ref_from_video_clk;
  logic        ref_from_ext_osc;
  logic        discontinuous_clk_ok;
  logic        config_loaded;
  logic [2:0]  e_txm;
  logic        e_coax;
  logic        e_sa;
  logic        e_indis;
  logic        e_cont;
  logic [1:0]  e_cs;
  logic [1:0]  e_lanes;
  logic [2:0]  s_a;
  logic [2:0]  s_b;
  logic [1:0]  resp;
  logic [31:0] data;
  int          failures    = 0;
  int          comparisons = 0;
  wire  [11:0] outs = {lane_enable, split_video_en, split_audio_en, input_port_enable, coax_cable_flag,
                       ref_from_video_clk, ref_from_ext_osc, discontinuous_clk_ok, config_loaded};

  always #5 core_clk = ~core_clk;

  mscl_strap_model i_mscl_strap_model (.mode_a(mode_a), .mode_b(mode_b), .config_strap_a(config_strap_a),
                                       .config_strap_b(config_strap_b));

  mscl_loader i_mscl_loader (.core_clk(core_clk), .rst(rst), .ce(ce), .config_strap_a(config_strap_a),
    .config_strap_b(config_strap_b), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .lane_enable(lane_enable), .split_video_en(split_video_en), .split_audio_en(split_audio_en),
    .input_port_enable(input_port_enable), .coax_cable_flag(coax_cable_flag),
    .ref_from_video_clk(ref_from_video_clk), .ref_from_ext_osc(ref_from_ext_osc),
    .discontinuous_clk_ok(discontinuous_clk_ok), .config_loaded(config_loaded));

  // ---------------------------------------------------------------
  // Reporting
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic guard(input int n);
    if (n >= 50) begin
      failures++;
      $display("MISMATCH at %0t: bus wait ran out", $time);
      end_of_test();
    end
  endtask

  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid || s_axi_wvalid) && n < 50);
    while (!s_axi_bvalid && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    guard(n);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (!s_axi_arready && n < 50);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    guard(n);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, 4'hF, r);
    check(32'(r), 32'(mscl_pkg::RESP_OKAY));
    repeat (2) @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check(d, exp);
    check(32'(r), 32'(mscl_pkg::RESP_OKAY));
  endtask

  // ---------------------------------------------------------------
  // Expected state
  // ---------------------------------------------------------------
  function automatic logic [11:0] exp_outs();
    logic [3:0] m;
    m = 4'hF >> (2'h3 - e_lanes);
    return {m, e_txm == mscl_pkg::TX_MODE_SPLIT, e_sa, !e_indis, e_coax, e_cs == 2'h0, e_cs[0], !e_cont, 1'b1};
  endfunction

  task automatic check_all();
    check(32'(outs), 32'(exp_outs()));
    rd(mscl_pkg::OFS_DUAL_LINK, {24'h0, e_coax, 4'h0, e_txm});
    rd(mscl_pkg::OFS_AUDIO_CFG, {27'h0, e_sa, 4'h0});
    rd(mscl_pkg::OFS_MAIN_CTL, {24'h0, e_cont, 3'h0, e_lanes, e_cs});
    rd(mscl_pkg::OFS_RESELECT, {31'h0, e_indis});
    rd(mscl_pkg::OFS_STRAP_STAT, {23'h0, 1'b1, 1'b0, s_b, 1'b0, s_a});
  endtask

  task automatic do_reset(input logic [2:0] a, input logic [2:0] b);
    rst    <= 1'b1;
    mode_a <= a;
    mode_b <= b;
    repeat (10) @(posedge core_clk);
    check(32'(outs), 32'h0);
    check(32'({s_axi_awready, s_axi_wready, s_axi_arready}), 32'h7);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    s_a     = a;
    s_b     = b;
    e_txm   = a[2] ? mscl_pkg::TX_MODE_SPLIT : mscl_pkg::TX_MODE_NORMAL;
    e_sa    = a[2];
    e_lanes = a[1:0];
    e_cs    = b[2] ? mscl_pkg::CLKSRC_EXT : mscl_pkg::CLKSRC_VIDEO;
    e_cont  = !b[2];
    e_coax  = b[1];
    e_indis = b[0];
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    for (int i = 0; i < 8; i++) begin
      do_reset(3'(i), 3'(7 - i));
      check_all();
      mode_a <= ~mode_a;
      mode_b <= ~mode_b;
      repeat (3) @(posedge core_clk);
      check_all();
    end
    $display("strap load test done");
    wr(mscl_pkg::OFS_RESELECT, 32'h1);
    e_indis = 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(mscl_pkg::OFS_MAIN_CTL, {24'h0, k[0], 3'h0, k[1:0], k[1:0]});
      e_cs    = k[1:0];
      e_lanes = k[1:0];
      e_cont  = k[0];
      check_all();
    end
    wr(mscl_pkg::OFS_DUAL_LINK, 32'h0000_0082);
    wr(mscl_pkg::OFS_AUDIO_CFG, 32'h0000_0010);
    wr(mscl_pkg::OFS_RESELECT, 32'h0000_0000);
    e_txm   = 3'h2;
    e_coax  = 1'b1;
    e_sa    = 1'b1;
    e_indis = 1'b0;
    check_all();
    $display("software override test done");
    axi_write(mscl_pkg::OFS_STRAP_STAT, 32'hFFFF_FFFF, 4'hF, resp);
    check(32'(resp), 32'(mscl_pkg::RESP_SLVERR));
    axi_write(8'h14, 32'hFFFF_FFFF, 4'hF, resp);
    check(32'(resp), 32'(mscl_pkg::RESP_SLVERR));
    axi_write(mscl_pkg::OFS_DUAL_LINK, 32'h0000_0000, 4'hE, resp);
    check(32'(resp), 32'(mscl_pkg::RESP_OKAY));
    axi_read(8'h14, data, resp);
    check(data, 32'h0);
    check(32'(resp), 32'(mscl_pkg::RESP_SLVERR));
    repeat (2) @(posedge core_clk);
    check_all();
    $display("refused access test done");
    ce <= 1'b0;
    do_reset(3'h6, 3'h5);
    check(32'(outs), 32'h0);
    ce <= 1'b1;
    repeat (3) @(posedge core_clk);
    check_all();
    $display("clock enable test done");
    end_of_test();
  end
endmodule
